// file: verification/can_dev_model.sv
// Behavioural device: message storage and one interface register set
`timescale 1ns/100ps
`default_nettype none
module can_dev_model
    import can_host_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  devAddr,
    input  wire logic [31:0] devWdata,
    input  wire logic        devWr,
    input  wire logic        devRd,
    output logic [31:0]      devRdata
);
    logic [31:0] mem [1:32][0:4];
    logic [31:0] ifr [0:4];
    logic [31:0] imask;
    int          bc;
    int          clrCnt;
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bc <= 0;
            clrCnt <= 0;
            devRdata <= 32'h0;
            mem <= '{default: 32'h0};
        end
        else
        begin
            bc <= (bc > 0) ? bc - 1 : 0;
            devRdata <= devRd ? ((devAddr == DEV_STATUS) ?
                {30'h0, bc != 0, 1'b0} : ifr[devAddr[4:2]]) : ~devRdata;
            if (devWr && devAddr < DEV_XFER)
                ifr[devAddr[4:2]] <= devWdata;
            if (devWr && devAddr == DEV_XFER)
            begin
                bc <= 3;
                if (devWdata[TB_WRITE])
                    mem[devWdata[5:0]] <= ifr;
                else
                    ifr <= mem[devWdata[5:0]];
                if (!devWdata[TB_WRITE] && devWdata[TB_CLR_FRESH])
                    mem[devWdata[5:0]][2][CB_FRESH] <= 1'b0;
                if (!devWdata[TB_WRITE] && devWdata[TB_CLR_IRQ])
                    mem[devWdata[5:0]][2][CB_PEND] <= 1'b0;
            end
            if (devWr && devAddr == DEV_CLR_STAT)
                clrCnt <= clrCnt + 1;
            if (devWr && devAddr == DEV_INT_MASK)
                imask <= devWdata;
        end
    end
    task automatic rx(input int f, l, input logic [31:0] d);
        int o;
        o = f;
        while (o < l && mem[o][2][CB_FRESH])
            o++;
        mem[o][2][CB_LOST] |= mem[o][2][CB_FRESH];
        mem[o][0][28:0] = {d[10:0], 18'h0};
        mem[o][3] = d;
        mem[o][2][CB_FRESH] = 1'b1;
        mem[o][2][CB_PEND] |= mem[o][2][CB_RX_DONE_IRQ_ENABLE];
        mem[o][2][CB_SENDREQ] = 1'b0;
    endtask
endmodule // can_dev_model
`default_nettype wire

// file: verification/can_msg_host_sva.sv
// Port assertions for the message object host controller
`timescale 1ns/100ps
`default_nettype none
module can_msg_host_sva
    import can_host_pkg::*;
#(
    parameter int POLL_LIMIT = POLL_LIMIT_DEF
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        busy,
    input wire logic [7:0]  devAddr,
    input wire logic [31:0] devWdata,
    input wire logic        devWr,
    input wire logic        devRd,
    input wire logic [31:0] devRdata
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    wire wId = devWr && devAddr == DEV_IDENT;
    wire wCtl = devWr && devAddr == DEV_CTRL;
    wire wXfr = devWr && devAddr == DEV_XFER && !devWdata[TB_WRITE];
    wire c7 = regWr && regAddr == HR_CMD && !busy && regWdata == 32'h107;
    wire c9 = regWr && regAddr == HR_CMD && !busy && regWdata == 32'h109;
    strobe_pulse_a:
        assert property (devWr || devRd |=> !devWr && !devRd)
        else $error("device strobe too long");
    std_id_a:
        assert property (wId && !devWdata[IB_EXT] |-> devWdata[17:0] == 0)
        else $error("standard id misplaced");
    obj_valid_a:
        assert property (wId |-> devWdata[IB_VALID])
        else $error("object left invalid");
    mask_dir_a:
        assert property (devWr && devAddr == DEV_MASK |-> devWdata[MB_DIRECTION_BIT])
        else $error("direction bit masked");
    fresh_req_a:
        assert property (wCtl && devWdata[CB_FRESH] |-> devWdata[CB_SENDREQ])
        else $error("fresh without request");
    read_clear_a:
        assert property (wXfr |-> devWdata[TB_CLR_FRESH] && devWdata[TB_CLR_IRQ])
        else $error("read without clear bits");
    clr_stat_a:
        assert property (c7 |=> busy ##2 devWr && devAddr == DEV_CLR_STAT)
        else $error("status clear not written");
    int_mask_a:
        assert property (c9 |=> busy ##2 devWr && devAddr == DEV_INT_MASK)
        else $error("interrupt mask not written");
    cover property (wXfr);
    cover property (c7);
    cover property (wCtl && devWdata[CB_FRESH]);
endmodule // can_msg_host_sva
bind can_msg_host can_msg_host_sva #(.POLL_LIMIT(POLL_LIMIT)) sva (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .busy(busy),
    .devAddr(devAddr), .devWdata(devWdata), .devWr(devWr),
    .devRd(devRd), .devRdata(devRdata));
`default_nettype wire

// file: verification/can_msg_host_test.sv
// Self-checking bench for the message object host controller
`timescale 1ns/100ps
`default_nettype none
module can_msg_host_test;
    import can_host_pkg::*;
    logic        clock, rst, regWr, regRd, busy, devWr, devRd;
    logic [7:0]  regAddr, devAddr;
    logic [31:0] regWdata, regRdata, devWdata, devRdata, rd, lf;
    logic [31:0] dq [$];
    int          err_total, comparisons;
    can_msg_host #(.POLL_LIMIT(8)) dut (.clock(clock), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .busy(busy),
        .devAddr(devAddr), .devWdata(devWdata), .devWr(devWr),
        .devRd(devRd), .devRdata(devRdata));
    can_dev_model dev (.clock(clock), .rst(rst), .devAddr(devAddr),
        .devWdata(devWdata), .devWr(devWr), .devRd(devRd),
        .devRdata(devRdata));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        summarize();
    end
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic summarize();
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWr <= w;
        regRd <= !w;
        @(posedge clock);
        {regWr, regRd} <= 2'b00;
        #1 rd = regRdata;
    endtask
    // Runs one command to its end, then fetches the status word
    task automatic cmd(input logic [3:0] c, input logic [5:0] o, l);
        bus(1'b1, HR_CMD, {10'h0, l, 2'h0, o, 4'h0, c});
        // Sampled away from the edge; a hang ends at the timeout
        while (busy !== 1'b0)
            @(negedge clock);
        bus(1'b0, HR_STAT, 32'h0);
    endtask
    initial
    begin
        {rst, regWr, regRd, regAddr, regWdata} = {1'b1, 42'h0};
        lf = 32'h70F12454;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, 8'h30, 32'h0);
        chk("unmapped", rd, 32'h0);
        lf = nxt(lf);
        bus(1'b1, HR_ID, {21'h0, lf[10:0]});
        bus(1'b1, HR_CFG, 32'h148);
        bus(1'b1, HR_DATA_A, lf);
        cmd(CMD_CFG_TX, 6'd3, 6'd0);
        chk("ident", dev.mem[3][0], {3'b110, lf[10:0], 18'h0});
        chk("ctrl", dev.mem[3][2] & 32'h1FFF, 32'h148);
        chk("data", dev.mem[3][3], lf);
        lf = nxt(lf);
        bus(1'b1, HR_DATA_A, lf);
        cmd(CMD_UPD_TX, 6'd3, 6'd0);
        chk("update", dev.mem[3][3], lf);
        chk("fresh", dev.mem[3][2][CB_FRESH], 1'b1);
        bus(1'b1, HR_CFG, 32'h88);
        cmd(CMD_CFG_RX, 6'd5, 6'd7);
        for (int o = 5; o <= 7; o++)
            chk("block end", dev.mem[o][2][CB_EOB], o == 7);
        @(negedge clock);
        for (int k = 0; k < 4; k++)
        begin
            lf = nxt(lf);
            dev.rx(5, 7, lf);
            if (k != 2)
                dq.push_back(lf);
        end
        while (dq.size() > 0)
        begin
            cmd(CMD_FIFO_READ, 6'd5, 6'd7);
            chk("got", rd[4], 1'b1);
            bus(1'b0, HR_RES_DA, 32'h0);
            chk("fifo", rd, dq.pop_front());
            bus(1'b0, HR_RES_CTRL, 32'h0);
            chk("flags", rd[CB_FRESH], 1'b1);
        end
        chk("pending", dev.mem[5][2][CB_PEND], 1'b0);
        chk("lost", dev.mem[7][2][CB_LOST], 1'b1);
        cmd(CMD_CLR_LOST, 6'd7, 6'd0);
        chk("lost", dev.mem[7][2][CB_LOST], 1'b0);
        cmd(CMD_REMOTE, 6'd6, 6'd0);
        chk("remote", dev.mem[6][2][CB_SENDREQ], 1'b1);
        cmd(CMD_CLR_STAT, 6'd1, 6'd0);
        chk("clear", dev.clrCnt, 1);
        lf = nxt(lf);
        bus(1'b1, HR_IMASK, lf);
        cmd(CMD_IMASK, 6'd1, 6'd0);
        chk("mask", dev.imask, lf);
        cmd(CMD_READ, 6'd0, 6'd0);
        chk("bad object", rd[2], 1'b1);
        summarize();
    end
endmodule // can_msg_host_test
`default_nettype wire

// file: verilog/can_host_pkg.sv
// Constants and types shared by the message object host controller
package can_host_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int OBJ_FIRST = 1;
    localparam int OBJ_LAST = 32;
    localparam int POLL_LIMIT_DEF = 1024;

    // Device side register map (one interface register set)
    localparam logic [7:0] DEV_IDENT = 8'h00;
    localparam logic [7:0] DEV_MASK = 8'h04;
    localparam logic [7:0] DEV_CTRL = 8'h08;
    localparam logic [7:0] DEV_DATA_A = 8'h0C;
    localparam logic [7:0] DEV_DATA_B = 8'h10;
    localparam logic [7:0] DEV_XFER = 8'h14;
    localparam logic [7:0] DEV_STATUS = 8'h18;
    localparam logic [7:0] DEV_CLR_STAT = 8'h1C;
    localparam logic [7:0] DEV_INT_MASK = 8'h20;

    // object_identifier_reg fields
    localparam int IB_EXT = 29;
    localparam int IB_DIR = 30;
    localparam int IB_VALID = 31;
    // identifier_mask word fields
    localparam int MB_MASK_EXT_ID_BIT = 29;
    localparam int MB_DIRECTION_BIT = 30;
    // object_control_reg fields
    localparam int CB_EOB = 4;
    localparam int CB_USE_ACCEPTANCE_MASK = 5;
    localparam int CB_TX_DONE_IRQ_ENABLE = 6;
    localparam int CB_RX_DONE_IRQ_ENABLE = 7;
    localparam int CB_RAE = 8;
    localparam int CB_SENDREQ = 9;
    localparam int CB_PEND = 10;
    localparam int CB_LOST = 11;
    localparam int CB_FRESH = 12;
    // transfer_command_reg fields
    localparam int TB_WRITE = 6;
    localparam int TB_CLR_FRESH = 7;
    localparam int TB_CLR_IRQ = 8;
    // controller_status_reg fields
    localparam int SB_TX = 0;
    localparam int SB_BUSY = 1;

    // Host register map
    localparam logic [7:0] HR_CMD = 8'h00;
    localparam logic [7:0] HR_ID = 8'h04;
    localparam logic [7:0] HR_CFG = 8'h08;
    localparam logic [7:0] HR_MSK = 8'h0C;
    localparam logic [7:0] HR_DATA_A = 8'h10;
    localparam logic [7:0] HR_DATA_B = 8'h14;
    localparam logic [7:0] HR_STAT = 8'h18;
    localparam logic [7:0] HR_RES_ID = 8'h1C;
    localparam logic [7:0] HR_RES_CTRL = 8'h20;
    localparam logic [7:0] HR_RES_DA = 8'h24;
    localparam logic [7:0] HR_RES_DB = 8'h28;
    localparam logic [7:0] HR_IMASK = 8'h2C;

    // Host config word fields
    localparam int HC_EXT = 4;
    localparam int HC_USE_ACCEPTANCE_MASK = 5;
    localparam int HC_TX_DONE_IRQ_ENABLE = 6;
    localparam int HC_RX_DONE_IRQ_ENABLE = 7;
    localparam int HC_RAE = 8;
    localparam int HC_SEND = 9;

    // Commands
    localparam logic [3:0] CMD_CFG_TX = 4'h1;
    localparam logic [3:0] CMD_CFG_RX = 4'h2;
    localparam logic [3:0] CMD_UPD_TX = 4'h3;
    localparam logic [3:0] CMD_READ = 4'h4;
    localparam logic [3:0] CMD_FIFO_READ = 4'h5;
    localparam logic [3:0] CMD_REMOTE = 4'h6;
    localparam logic [3:0] CMD_CLR_STAT = 4'h7;
    localparam logic [3:0] CMD_CLR_LOST = 4'h8;
    localparam logic [3:0] CMD_IMASK = 4'h9;

    typedef enum logic [1:0] {OP_WR, OP_RD, OP_POLL} opKind_t;

    typedef struct packed {
        opKind_t     kind;
        logic [7:0]  addr;
        logic [31:0] data;
        logic        last;
    } devOp_t;
endpackage

// file: verilog/can_msg_host.sv
// Host controller that sets up and services CAN message objects
// What this block does
// - Standard ID goes to bits 28:18
// - Request and remote answer set after data
// - Acceptance mask used; direction never masked
// - Both data words written whole before transfer
// - Fresh flag written together with send request
// - Read only while device not transmitting
// - FIFO members end-of-block clear except last
// - FIFO read clears fresh and pending flags
// - FIFO members read in ascending order
// - Status interrupt cleared via clear-status write
`timescale 1ns/100ps
`default_nettype none
module can_msg_host #(
    parameter int POLL_LIMIT = can_host_pkg::POLL_LIMIT_DEF
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdata,
    output logic             busy,
    output logic [7:0]       devAddr,
    output logic [31:0]      devWdata,
    output logic             devWr,
    output logic             devRd,
    input  wire logic [31:0] devRdata
);
    import can_host_pkg::*;

    typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_WAIT} hostState_t;

    typedef struct packed {
        hostState_t  st;
        logic [3:0]  cmd;
        logic [5:0]  obj;
        logic [5:0]  lastObj;
        logic [3:0]  step;
        logic [9:0]  cfg;
        logic [28:0] id;
        logic [29:0] msk;
        logic [31:0] dataA;
        logic [31:0] dataB;
        logic [31:0] imask;
        logic [31:0] resId;
        logic [31:0] resCtrl;
        logic [31:0] resDa;
        logic [31:0] resDb;
        logic        done;
        logic        err;
        logic        refused;
        logic        gotMsg;
        logic        start;
        logic [31:0] rdata;
        logic        busyOut;
    } host_t;

    host_t  r_r;
    host_t  r_nxt;
    devOp_t curOp;

    dev_op_if accBus ();

    dev_access #(
        .POLL_LIMIT (POLL_LIMIT)
    ) u_access (
        .clock    (clock),
        .rst      (rst),
        .req      (accBus.worker),
        .devAddr  (devAddr),
        .devWdata (devWdata),
        .devWr    (devWr),
        .devRd    (devRd),
        .devRdata (devRdata)
    );

    function automatic devOp_t mkOp(input opKind_t k, input logic [7:0] a,
                                    input logic [31:0] d, input logic l);
        devOp_t o;
        o.kind = k;
        o.addr = a;
        o.data = d;
        o.last = l;
        return o;
    endfunction

    // Device access for the current step of the running command
    function automatic devOp_t opFor(input host_t s);
        logic [31:0] idw;
        logic [31:0] mskw;
        logic [31:0] ctl;
        logic [31:0] xw;
        logic [31:0] xr;
        logic [31:0] busyM;
        devOp_t      o;
        idw = '0;
        idw[28:0] = s.cfg[HC_EXT] ? s.id : {s.id[10:0], 18'h00000};
        idw[IB_EXT] = s.cfg[HC_EXT];
        idw[IB_VALID] = 1'b1;
        mskw = '0;
        mskw[28:0] = s.msk[28:0];
        mskw[MB_MASK_EXT_ID_BIT] = s.msk[29];
        mskw[MB_DIRECTION_BIT] = 1'b1;
        ctl = '0;
        ctl[3:0] = s.cfg[3:0];
        ctl[CB_USE_ACCEPTANCE_MASK] = s.cfg[HC_USE_ACCEPTANCE_MASK];
        ctl[CB_TX_DONE_IRQ_ENABLE] = s.cfg[HC_TX_DONE_IRQ_ENABLE];
        ctl[CB_RX_DONE_IRQ_ENABLE] = s.cfg[HC_RX_DONE_IRQ_ENABLE];
        xw = '0;
        xw[5:0] = s.obj;
        xw[TB_WRITE] = 1'b1;
        xr = '0;
        xr[5:0] = s.obj;
        xr[TB_CLR_FRESH] = 1'b1;
        xr[TB_CLR_IRQ] = 1'b1;
        busyM = '0;
        busyM[SB_BUSY] = 1'b1;
        o = mkOp(OP_WR, DEV_CLR_STAT, 32'h0, 1'b1);
        case (s.cmd)
            CMD_CFG_TX:
            begin
                idw[IB_DIR] = 1'b1;
                case (s.step)
                    4'h0: o = mkOp(OP_WR, DEV_IDENT, idw, 1'b0);
                    4'h1: o = mkOp(OP_WR, DEV_MASK, mskw, 1'b0);
                    4'h2: o = mkOp(OP_WR, DEV_CTRL, ctl, 1'b0);
                    4'h3: o = mkOp(OP_WR, DEV_DATA_A, s.dataA, 1'b0);
                    4'h4: o = mkOp(OP_WR, DEV_DATA_B, s.dataB, 1'b0);
                    4'h5: o = mkOp(OP_WR, DEV_XFER, xw, 1'b0);
                    4'h6: o = mkOp(OP_POLL, DEV_STATUS, busyM, 1'b0);
                    4'h7:
                    begin
                        // Request bits go in only once the data are stored
                        ctl[CB_RAE] = s.cfg[HC_RAE];
                        ctl[CB_SENDREQ] = s.cfg[HC_SEND];
                        o = mkOp(OP_WR, DEV_CTRL, ctl, 1'b0);
                    end
                    4'h8: o = mkOp(OP_WR, DEV_XFER, xw, 1'b0);
                    default: o = mkOp(OP_POLL, DEV_STATUS, busyM, 1'b1);
                endcase
            end
            CMD_CFG_RX:
            begin
                ctl[CB_EOB] = (s.obj == s.lastObj);
                case (s.step)
                    4'h0: o = mkOp(OP_WR, DEV_IDENT, idw, 1'b0);
                    4'h1: o = mkOp(OP_WR, DEV_MASK, mskw, 1'b0);
                    4'h2: o = mkOp(OP_WR, DEV_CTRL, ctl, 1'b0);
                    4'h3: o = mkOp(OP_WR, DEV_XFER, xw, 1'b0);
                    default: o = mkOp(OP_POLL, DEV_STATUS, busyM, 1'b1);
                endcase
            end
            CMD_UPD_TX:
            begin
                ctl[CB_FRESH] = 1'b1;
                ctl[CB_SENDREQ] = 1'b1;
                ctl[CB_RAE] = s.cfg[HC_RAE];
                case (s.step)
                    4'h0: o = mkOp(OP_WR, DEV_DATA_A, s.dataA, 1'b0);
                    4'h1: o = mkOp(OP_WR, DEV_DATA_B, s.dataB, 1'b0);
                    4'h2: o = mkOp(OP_WR, DEV_CTRL, ctl, 1'b0);
                    4'h3: o = mkOp(OP_WR, DEV_XFER, xw, 1'b0);
                    default: o = mkOp(OP_POLL, DEV_STATUS, busyM, 1'b1);
                endcase
            end
            CMD_READ, CMD_FIFO_READ:
            begin
                case (s.step)
                    4'h0: o = mkOp(OP_POLL, DEV_STATUS, 32'h1 << SB_TX, 1'b0);
                    4'h1: o = mkOp(OP_WR, DEV_XFER, xr, 1'b0);
                    4'h2: o = mkOp(OP_POLL, DEV_STATUS, busyM, 1'b0);
                    4'h3: o = mkOp(OP_RD, DEV_IDENT, 32'h0, 1'b0);
                    4'h4: o = mkOp(OP_RD, DEV_CTRL, 32'h0, 1'b0);
                    4'h5: o = mkOp(OP_RD, DEV_DATA_A, 32'h0, 1'b0);
                    default: o = mkOp(OP_RD, DEV_DATA_B, 32'h0, 1'b1);
                endcase
            end
            CMD_REMOTE, CMD_CLR_LOST:
            begin
                // Lost flag is written back as zero; the device never drops it
                ctl[CB_SENDREQ] = (s.cmd == CMD_REMOTE);
                case (s.step)
                    4'h0: o = mkOp(OP_WR, DEV_CTRL, ctl, 1'b0);
                    4'h1: o = mkOp(OP_WR, DEV_XFER, xw, 1'b0);
                    default: o = mkOp(OP_POLL, DEV_STATUS, busyM, 1'b1);
                endcase
            end
            CMD_IMASK: o = mkOp(OP_WR, DEV_INT_MASK, s.imask, 1'b1);
            default: o = mkOp(OP_WR, DEV_CLR_STAT, 32'h0, 1'b1);
        endcase
        return o;
    endfunction

    assign curOp = opFor(r_r);
    assign accBus.start = r_r.start;
    assign accBus.op = curOp;

    always_comb
    begin
        logic       cmdOk;
        logic       multi;
        logic [5:0] cmdObj;
        logic [5:0] cmdLast;
        r_nxt = r_r;
        r_nxt.start = 1'b0;
        cmdObj = regWdata[13:8];
        cmdLast = (regWdata[21:16] == 6'h00) ? cmdObj : regWdata[21:16];
        cmdOk = (cmdObj >= 6'(OBJ_FIRST)) && (cmdLast <= 6'(OBJ_LAST))
                && (cmdLast >= cmdObj) && (regWdata[3:0] >= CMD_CFG_TX)
                && (regWdata[3:0] <= CMD_IMASK);
        multi = (r_r.cmd == CMD_CFG_RX) || (r_r.cmd == CMD_FIFO_READ);

        if (regWr)
        begin
            if (r_r.st != HS_IDLE)
            begin
                r_nxt.refused = 1'b1;
            end
            else
            begin
                case (regAddr)
                    HR_CMD:
                    begin
                        r_nxt.done = 1'b0;
                        r_nxt.gotMsg = 1'b0;
                        r_nxt.refused = 1'b0;
                        r_nxt.err = !cmdOk;
                        if (cmdOk)
                        begin
                            r_nxt.cmd = regWdata[3:0];
                            r_nxt.obj = cmdObj;
                            r_nxt.lastObj = cmdLast;
                            r_nxt.step = 4'h0;
                            r_nxt.st = HS_ISSUE;
                        end
                    end
                    HR_ID: r_nxt.id = regWdata[28:0];
                    HR_CFG: r_nxt.cfg = regWdata[9:0];
                    HR_MSK: r_nxt.msk = regWdata[29:0];
                    HR_DATA_A: r_nxt.dataA = regWdata;
                    HR_DATA_B: r_nxt.dataB = regWdata;
                    HR_IMASK: r_nxt.imask = regWdata;
                    default: r_nxt.refused = 1'b0;
                endcase
            end
        end

        case (r_r.st)
            HS_ISSUE:
            begin
                r_nxt.start = 1'b1;
                r_nxt.st = HS_WAIT;
            end
            HS_WAIT:
            begin
                if (accBus.done)
                begin
                    if (curOp.kind == OP_RD)
                    begin
                        case (curOp.addr)
                            DEV_IDENT: r_nxt.resId = accBus.rdata;
                            DEV_CTRL: r_nxt.resCtrl = accBus.rdata;
                            DEV_DATA_A: r_nxt.resDa = accBus.rdata;
                            default: r_nxt.resDb = accBus.rdata;
                        endcase
                    end
                    if (accBus.fail)
                    begin
                        r_nxt.err = 1'b1;
                        r_nxt.done = 1'b1;
                        r_nxt.st = HS_IDLE;
                    end
                    else if (!curOp.last)
                    begin
                        r_nxt.step = r_r.step + 4'h1;
                        r_nxt.st = HS_ISSUE;
                    end
                    else if (multi && r_r.obj != r_r.lastObj
                             && !(r_r.cmd == CMD_FIFO_READ
                                  && r_r.resCtrl[CB_FRESH]))
                    begin
                        // Next member upward, lowest number first
                        r_nxt.obj = r_r.obj + 6'h01;
                        r_nxt.step = 4'h0;
                        r_nxt.st = HS_ISSUE;
                    end
                    else
                    begin
                        r_nxt.gotMsg = (r_r.cmd == CMD_READ
                                        || r_r.cmd == CMD_FIFO_READ)
                                       && r_r.resCtrl[CB_FRESH];
                        r_nxt.done = 1'b1;
                        r_nxt.st = HS_IDLE;
                    end
                end
            end
            default:
            begin
            end
        endcase

        if (regRd)
        begin
            case (regAddr)
                HR_ID: r_nxt.rdata = {3'h0, r_r.id};
                HR_CFG: r_nxt.rdata = {22'h0, r_r.cfg};
                HR_MSK: r_nxt.rdata = {2'h0, r_r.msk};
                HR_DATA_A: r_nxt.rdata = r_r.dataA;
                HR_DATA_B: r_nxt.rdata = r_r.dataB;
                HR_STAT: r_nxt.rdata = {26'h0, r_r.obj == r_r.lastObj,
                                        r_r.gotMsg, r_r.refused, r_r.err,
                                        r_r.done, r_r.st != HS_IDLE};
                HR_RES_ID: r_nxt.rdata = r_r.resId;
                HR_RES_CTRL: r_nxt.rdata = r_r.resCtrl;
                HR_RES_DA: r_nxt.rdata = r_r.resDa;
                HR_RES_DB: r_nxt.rdata = r_r.resDb;
                HR_IMASK: r_nxt.rdata = r_r.imask;
                default: r_nxt.rdata = 32'h0;
            endcase
        end
        else
        begin
            r_nxt.rdata = 32'h0;
        end
        r_nxt.busyOut = (r_nxt.st != HS_IDLE);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            r_r <= '0;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    assign regRdata = r_r.rdata;
    assign busy = r_r.busyOut;
endmodule // can_msg_host
`default_nettype wire

// file: verilog/dev_access.sv
// Drives single writes, reads and polls on the device register port
`timescale 1ns/100ps
`default_nettype none
module dev_access #(
    parameter int POLL_LIMIT = can_host_pkg::POLL_LIMIT_DEF
) (
    input  wire logic        clock,
    input  wire logic        rst,
    dev_op_if.worker         req,
    output logic [7:0]       devAddr,
    output logic [31:0]      devWdata,
    output logic             devWr,
    output logic             devRd,
    input  wire logic [31:0] devRdata
);
    import can_host_pkg::*;

    typedef enum logic {ST_IDLE, ST_RDWAIT} accState_t;

    typedef struct packed {
        accState_t   st;
        opKind_t     kind;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] mask;
        logic        wr;
        logic        rd;
        logic [15:0] cnt;
        logic        done;
        logic        fail;
        logic [31:0] rdata;
    } acc_t;

    acc_t r_r;
    acc_t r_nxt;

    always_comb
    begin
        r_nxt = r_r;
        r_nxt.wr = 1'b0;
        r_nxt.rd = 1'b0;
        r_nxt.done = 1'b0;
        r_nxt.fail = 1'b0;
        case (r_r.st)
            ST_IDLE:
            begin
                if (req.start)
                begin
                    r_nxt.addr = req.op.addr;
                    r_nxt.kind = req.op.kind;
                    r_nxt.mask = req.op.data;
                    r_nxt.cnt = 16'h0000;
                    if (req.op.kind == OP_WR)
                    begin
                        r_nxt.wdata = req.op.data;
                        r_nxt.wr = 1'b1;
                        r_nxt.done = 1'b1;
                    end
                    else
                    begin
                        r_nxt.rd = 1'b1;
                        r_nxt.st = ST_RDWAIT;
                    end
                end
            end
            ST_RDWAIT:
            begin
                r_nxt.rdata = devRdata;
                if (r_r.rd)
                begin
                    // Device answers in the cycle after the strobe
                    r_nxt.rdata = r_r.rdata;
                end
                else if (r_r.kind == OP_RD || (devRdata & r_r.mask) == 32'h0)
                begin
                    r_nxt.done = 1'b1;
                    r_nxt.st = ST_IDLE;
                end
                else if (r_r.cnt == 16'(POLL_LIMIT - 1))
                begin
                    // Device never settled: give up rather than hang
                    r_nxt.done = 1'b1;
                    r_nxt.fail = 1'b1;
                    r_nxt.st = ST_IDLE;
                end
                else
                begin
                    r_nxt.cnt = r_r.cnt + 16'h0001;
                    r_nxt.rd = 1'b1;
                end
            end
            default:
            begin
                r_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            r_r <= '0;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    assign devAddr = r_r.addr;
    assign devWdata = r_r.wdata;
    assign devWr = r_r.wr;
    assign devRd = r_r.rd;
    assign req.done = r_r.done;
    assign req.fail = r_r.fail;
    assign req.rdata = r_r.rdata;
endmodule // dev_access
`default_nettype wire

// file: verilog/dev_op_if.sv
// One device access request and its answer
`timescale 1ns/100ps
`default_nettype none
interface dev_op_if;
    import can_host_pkg::*;
    logic        start;
    devOp_t      op;
    logic        done;
    logic        fail;
    logic [31:0] rdata;
    modport master (output start, output op, input done, input fail,
                    input rdata);
    modport worker (input start, input op, output done, output fail,
                    output rdata);
endinterface
`default_nettype wire
